/* verilog/usdb_pkg.sv */
package usdb_pkg;

    localparam int ADDR_W     = 3;
    localparam int DATA_W     = 16;
    localparam int BAUD_DIV_W = 12;
    localparam int CHAR_W     = 9;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_DATA     = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_BAUD     = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h5;

    // Control fields
    localparam int CTL_TX_EN    = 0;
    localparam int CTL_RX_EN    = 1;
    localparam int CTL_DBL      = 2;
    localparam int CTL_SYNC     = 3;
    localparam int CTL_NINTH    = 4;
    localparam int CTL_SIZE_LSB = 5;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0060;

    // Status fields
    localparam int ST_RXC = 0;
    localparam int ST_TXE = 1;
    localparam int ST_TXC = 2;
    localparam int ST_OVR = 3;
    localparam int ST_FE  = 4;
    localparam int ST_RX9 = 5;

    // Interrupt event bits
    localparam int IRQ_RXC = 0;
    localparam int IRQ_TXE = 1;
    localparam int IRQ_TXC = 2;
    localparam int IRQ_OVR = 3;
    localparam int IRQ_W   = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    localparam logic [BAUD_DIV_W-1:0] BAUD_RESET = 12'h000;

    // Samples per bit
    localparam logic [4:0] OS_NORMAL = 5'h10;
    localparam logic [4:0] OS_DOUBLE = 5'h08;

    localparam logic [2:0] SIZE_9BIT = 3'h7;

    function automatic logic [3:0] usdb_char_bits(input logic [2:0] size);
        // Codes 4 to 6 are unused and fall back on their low bits
        return (size == SIZE_9BIT) ? 4'h9 : 4'h5 + {2'h0, size[1:0]};
    endfunction

endpackage

/* verilog/usdb_baud_gen.sv */
`timescale 1ns/100ps
module usdb_baud_gen
    import usdb_pkg::*;
#(
    parameter int DIV_W = BAUD_DIV_W
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             restart,
    output logic                  tick
);

    logic [DIV_W-1:0] cnt_q;
    logic             tick_q;
    logic             at_zero;

    assign at_zero = (cnt_q == '0);
    assign tick    = tick_q;

    // Period is divisor + 1 clocks; zero ticks every clock
    always_ff @(posedge mclk) begin
        if (!resetn || restart) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= at_zero ? divisor : cnt_q - 1'b1;
            tick_q <= at_zero;
        end
    end

endmodule // usdb_baud_gen

/* verilog/usdb_serial_core.sv */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
module usdb_serial_core
    import usdb_pkg::*;
#(
    parameter int DIV_W = BAUD_DIV_W
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    input  wire logic              rx_pin,
    output logic                   serial_out_pin,
    output logic                   irq
);

    if (DIV_W < 1 || DIV_W > DATA_W) begin : g_bad_div
        $error("Divisor width must fit the data bus");
    end

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } usdb_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } usdb_rx_state_t;

    // Register state
    logic [DATA_W-1:0]     ctrl_q;
    logic [DIV_W-1:0]      baud_q;
    logic [IRQ_W-1:0]      irq_st_q;
    logic [IRQ_W-1:0]      irq_st_d;
    logic [IRQ_W-1:0]      irq_mask_q;
    logic [IRQ_W-1:0]      irq_ev;
    logic                  irq_q;
    logic [DATA_W-1:0]     rdata_q;
    logic [DATA_W-1:0]     rd_val;
    logic [DATA_W-1:0]     status_w;

    // Decode
    logic                  wr_data;
    logic                  wr_ctrl;
    logic                  wr_baud;
    logic                  wr_irq_st;
    logic                  wr_irq_mask;
    logic                  rd_data;

    // Control fields
    logic                  tx_en;
    logic                  rx_en;
    logic [2:0]            char_size;
    logic [3:0]            nbits;
    logic [4:0]            os_n;
    logic [4:0]            os_last;
    logic [4:0]            os_half;
    logic                  samp_tick;

    // Transmit side
    logic                  thb_valid_q;
    logic [CHAR_W-1:0]     thb_data_q;
    usdb_tx_state_t        tx_state_q;
    logic [4:0]            tx_os_q;
    logic [3:0]            tx_bit_q;
    logic [CHAR_W-1:0]     tx_sh_q;
    logic                  tx_out_q;
    logic                  tx_load;
    logic                  tx_bit_end;
    logic                  tx_done;

    // Receive side
    logic                  rx_meta_q;
    logic                  rx_sync_q;
    usdb_rx_state_t        rx_state_q;
    logic [4:0]            rx_os_q;
    logic [3:0]            rx_bit_q;
    logic [CHAR_W-1:0]     rx_sh_q;
    logic                  rx_ev;
    logic                  rx_push;
    logic [CHAR_W-1:0]     rx_word;
    logic                  push_ok;
    logic                  pop;
    logic                  overrun;
    logic                  ovr_q;

    // Receive queue
    logic [CHAR_W:0]       fifo_mem [2];
    logic [1:0]            fifo_cnt_q;
    logic [1:0]            fifo_cnt_d;
    logic                  fifo_rp_q;
    logic                  fifo_wp_q;
    logic [CHAR_W:0]       head;

    // One address, direction picks the buffer
    assign wr_data     = reg_wr && (reg_addr == ADDR_DATA);
    assign rd_data     = reg_rd && (reg_addr == ADDR_DATA);
    assign wr_ctrl     = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_baud     = reg_wr && (reg_addr == ADDR_BAUD);
    assign wr_irq_st   = reg_wr && (reg_addr == ADDR_IRQ_STAT);
    assign wr_irq_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);

    assign tx_en     = ctrl_q[CTL_TX_EN];
    assign rx_en     = ctrl_q[CTL_RX_EN];
    assign char_size = ctrl_q[CTL_SIZE_LSB +: 3];
    assign nbits     = usdb_char_bits(char_size);

    // Double speed only counts in asynchronous mode
    assign os_n    = (ctrl_q[CTL_DBL] && !ctrl_q[CTL_SYNC]) ? OS_DOUBLE : OS_NORMAL;
    assign os_last = os_n - 5'h01;
    assign os_half = (os_n >> 1) - 5'h01;

    usdb_baud_gen #(
        .DIV_W   (DIV_W)
    ) u_baud (
        .mclk    (mclk),
        .resetn  (resetn),
        .divisor (baud_q),
        .restart (wr_baud),
        .tick    (samp_tick)
    );

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_q     <= CTRL_RESET;
            baud_q     <= DIV_W'(BAUD_RESET);
            irq_mask_q <= IRQ_MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata;
            end
            if (wr_baud) begin
                baud_q <= reg_wdata[DIV_W-1:0];
            end
            if (wr_irq_mask) begin
                irq_mask_q <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // Holding buffer; ninth bit is latched from control at write time
    assign tx_load = tx_en && thb_valid_q && (tx_state_q == TX_IDLE);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            thb_valid_q <= 1'b0;
            thb_data_q  <= '0;
        end else if (tx_load) begin
            thb_valid_q <= 1'b0;
        end else if (wr_data && !thb_valid_q) begin
            thb_valid_q <= 1'b1;
            thb_data_q  <= {ctrl_q[CTL_NINTH], reg_wdata[7:0]};
        end
    end

    assign tx_bit_end = samp_tick && (tx_os_q == os_last);
    assign tx_done    = tx_bit_end && (tx_state_q == TX_STOP);

    // Only nbits leave the shifter, so upper bits never reach the pin
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tx_state_q <= TX_IDLE;
            tx_bit_q   <= '0;
            tx_sh_q    <= '0;
            tx_out_q   <= 1'b1;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: if (tx_load) begin
                    tx_state_q <= TX_START;
                    tx_sh_q    <= thb_data_q;
                    tx_out_q   <= 1'b0;
                end
                TX_START: if (tx_bit_end) begin
                    tx_state_q <= TX_DATA;
                    tx_out_q   <= tx_sh_q[0];
                    tx_sh_q    <= tx_sh_q >> 1;
                    tx_bit_q   <= '0;
                end
                TX_DATA: if (tx_bit_end) begin
                    if (tx_bit_q == nbits - 4'h1) begin
                        tx_state_q <= TX_STOP;
                        tx_out_q   <= 1'b1;
                    end else begin
                        tx_out_q <= tx_sh_q[0];
                        tx_sh_q  <= tx_sh_q >> 1;
                        tx_bit_q <= tx_bit_q + 4'h1;
                    end
                end
                TX_STOP: if (tx_bit_end) begin
                    tx_state_q <= TX_IDLE;
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || tx_state_q == TX_IDLE) begin
            tx_os_q <= '0;
        end else if (samp_tick) begin
            tx_os_q <= (tx_os_q == os_last) ? 5'h00 : tx_os_q + 5'h01;
        end
    end

    // Pin passes two flops before any logic reads it
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    assign rx_ev   = samp_tick && (rx_os_q == ((rx_state_q == RX_START) ? os_half : os_last));
    assign rx_push = rx_ev && (rx_state_q == RX_STOP);

    // Start is rechecked mid-bit to reject glitches
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rx_state_q <= RX_IDLE;
            rx_bit_q   <= '0;
            rx_sh_q    <= '0;
        end else begin
            unique case (rx_state_q)
                RX_IDLE: if (!rx_sync_q) begin
                    rx_state_q <= RX_START;
                end
                RX_START: if (rx_ev) begin
                    rx_state_q <= rx_sync_q ? RX_IDLE : RX_DATA;
                    rx_bit_q   <= '0;
                end
                RX_DATA: if (rx_ev) begin
                    rx_sh_q  <= {rx_sync_q, rx_sh_q[CHAR_W-1:1]};
                    rx_bit_q <= rx_bit_q + 4'h1;
                    if (rx_bit_q == nbits - 4'h1) begin
                        rx_state_q <= RX_STOP;
                    end
                end
                RX_STOP: if (rx_ev) begin
                    rx_state_q <= RX_IDLE;
                end
                default: rx_state_q <= RX_IDLE;
            endcase
            if (!rx_en) begin
                rx_state_q <= RX_IDLE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || rx_state_q == RX_IDLE) begin
            rx_os_q <= '0;
        end else if (samp_tick) begin
            rx_os_q <= rx_ev ? 5'h00 : rx_os_q + 5'h01;
        end
    end

    // Right-justify the character; shifted-in zeros fill unused bits
    assign rx_word = rx_sh_q >> (4'h9 - nbits);

    // Any data read pops, bit tests included
    assign pop        = rd_data && (fifo_cnt_q != 2'h0);
    assign push_ok    = rx_push && ((fifo_cnt_q != 2'h2) || pop);
    assign overrun    = rx_push && !push_ok;
    assign fifo_cnt_d = fifo_cnt_q + {1'b0, push_ok} - {1'b0, pop};
    assign head       = fifo_mem[fifo_rp_q];

    always_ff @(posedge mclk) begin
        if (push_ok) begin
            fifo_mem[fifo_wp_q] <= {!rx_sync_q, rx_word};
        end
    end

    // Disabling the receiver flushes the queue
    always_ff @(posedge mclk) begin
        if (!resetn || !rx_en) begin
            fifo_cnt_q <= 2'h0;
            fifo_rp_q  <= 1'b0;
            fifo_wp_q  <= 1'b0;
        end else begin
            fifo_cnt_q <= fifo_cnt_d;
            fifo_rp_q  <= fifo_rp_q ^ pop;
            fifo_wp_q  <= fifo_wp_q ^ push_ok;
        end
    end

    // Set wins over the clear by read
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ovr_q <= 1'b0;
        end else if (overrun) begin
            ovr_q <= 1'b1;
        end else if (pop || !rx_en) begin
            ovr_q <= 1'b0;
        end
    end

    always_comb begin
        status_w         = '0;
        status_w[ST_RXC] = (fifo_cnt_q != 2'h0);
        status_w[ST_TXE] = !thb_valid_q;
        status_w[ST_TXC] = !thb_valid_q && (tx_state_q == TX_IDLE);
        status_w[ST_OVR] = ovr_q;
        status_w[ST_FE]  = (fifo_cnt_q != 2'h0) && head[CHAR_W];
        status_w[ST_RX9] = (fifo_cnt_q != 2'h0) && head[CHAR_W-1];
    end

    // Sticky events, write one to clear, event wins
    assign irq_ev[IRQ_RXC] = push_ok;
    assign irq_ev[IRQ_TXE] = tx_load;
    assign irq_ev[IRQ_TXC] = tx_done && !thb_valid_q;
    assign irq_ev[IRQ_OVR] = overrun;
    assign irq_st_d = (irq_st_q & ~(wr_irq_st ? reg_wdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | irq_ev;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_st_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            irq_q    <= |(irq_st_q & irq_mask_q);
        end
    end

    // Empty queue reads zero; unmapped offsets read zero
    assign rd_val =
        (reg_addr == ADDR_DATA)     ? {8'h00, (fifo_cnt_q != 2'h0) ? head[7:0] : 8'h00} :
        (reg_addr == ADDR_CTRL)     ? ctrl_q :
        (reg_addr == ADDR_STATUS)   ? status_w :
        (reg_addr == ADDR_BAUD)     ? DATA_W'(baud_q) :
        (reg_addr == ADDR_IRQ_STAT) ? DATA_W'(irq_st_q) :
        (reg_addr == ADDR_IRQ_MASK) ? DATA_W'(irq_mask_q) : '0;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd ? rd_val : '0;
        end
    end

    assign reg_rdata      = rdata_q;
    assign serial_out_pin = tx_out_q;
    assign irq            = irq_q;

endmodule // usdb_serial_core

/* test/usdb_props.sv */
`timescale 1ns/100ps
module usdb_props
    import usdb_pkg::*;
#(
    parameter int DIV_W = BAUD_DIV_W
) (
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              rx_pin,
    input wire logic              serial_out_pin,
    input wire logic              irq
);
    logic [DIV_W-1:0] baud_q;
    logic [IRQ_W-1:0] mask_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Shadow copies of what software last wrote
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            baud_q <= DIV_W'(BAUD_RESET);
            mask_q <= IRQ_MASK_RESET;
        end else if (reg_wr && reg_addr == ADDR_BAUD) begin
            baud_q <= reg_wdata[DIV_W-1:0];
        end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
            mask_q <= reg_wdata[IRQ_W-1:0];
        end
    end

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside read cycle");
    data_width_a: assert property (reg_rd && reg_addr == ADDR_DATA |=> reg_rdata[15:8] == 8'h00)
        else $error("upper data bits not zero");
    unmapped_zero_a: assert property (reg_rd && reg_addr > ADDR_IRQ_MASK |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    reset_idle_a: assert property ($rose(resetn) |-> serial_out_pin && !irq)
        else $error("outputs not idle after reset");
    start_len_a: assert property ($fell(serial_out_pin) |-> (!serial_out_pin) [*8])
        else $error("start bit too short");
    irq_masked_a: assert property (mask_q == '0 && $past(mask_q) == '0 && $past(mask_q, 2) == '0 |-> !irq)
        else $error("interrupt while all masked");
    baud_back_a: assert property (reg_rd && reg_addr == ADDR_BAUD |=> reg_rdata[DIV_W-1:0] == $past(baud_q))
        else $error("divisor readback wrong");
    mask_back_a: assert property (reg_rd && reg_addr == ADDR_IRQ_MASK |=> reg_rdata[IRQ_W-1:0] == $past(mask_q))
        else $error("mask readback wrong");
endmodule // usdb_props

bind usdb_serial_core usdb_props #(.DIV_W(DIV_W)) u_props (
    .mclk          (mclk),
    .resetn        (resetn),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .rx_pin        (rx_pin),
    .serial_out_pin(serial_out_pin),
    .irq           (irq)
);

/* test/usdb_remote.sv */
`timescale 1ns/100ps
module usdb_remote (
    input  wire logic mclk,
    input  wire logic serial_out_pin,
    output logic      rx_pin
);
    int         bc = 16;
    int         nb = 8;
    logic [8:0] rxq[$];
    logic [8:0] sh;

    // Line idles high between frames
    initial rx_pin = 1'b1;

    task automatic send(input logic [8:0] d);
        for (int i = -1; i <= nb; i++) begin
            rx_pin <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : d[i];
            repeat (bc) @(posedge mclk);
        end
    endtask

    // Mid-bit sampling, so a wrong bit time garbles the char
    always begin
        @(negedge serial_out_pin);
        repeat (bc / 2) @(posedge mclk);
        sh = '0;
        for (int i = 0; i < nb; i++) begin
            repeat (bc) @(posedge mclk);
            sh[i] = serial_out_pin;
        end
        repeat (bc) @(posedge mclk);
        rxq.push_back(serial_out_pin === 1'b1 ? sh : 'x);
    end
endmodule // usdb_remote

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench
    import usdb_pkg::*;
;
    logic              mclk;
    logic              resetn;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              rx_pin;
    logic              serial_out_pin;
    logic              irq;
    int                fail_count;
    int                n_tests;

    usdb_serial_core dut (
        .mclk          (mclk),
        .resetn        (resetn),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .rx_pin        (rx_pin),
        .serial_out_pin(serial_out_pin),
        .irq           (irq)
    );

    usdb_remote remote (
        .mclk          (mclk),
        .serial_out_pin(serial_out_pin),
        .rx_pin        (rx_pin)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic stop_test;
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_ch(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: char got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Data location is only read or written whole, never bit-tested
    task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic getc(input logic [8:0] exp);
        int k = 0;
        while (remote.rxq.size() == 0 && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        chk_ch(remote.rxq.size() != 0 ? remote.rxq.pop_front() : 'x, exp);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk);
        #1 chk({15'h0000, irq}, {15'h0000, e});
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        stop_test();
    end

    initial begin
        resetn     = 1'b0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        fail_count = 0;
        n_tests    = 0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rc(ADDR_STATUS, 16'h0006);
        rc(ADDR_CTRL, CTRL_RESET);
        rc(ADDR_BAUD, 16'h0000);
        rc(ADDR_IRQ_MASK, 16'h0000);
        rc(3'h6, 16'h0000);
        rc(ADDR_DATA, 16'h0000);
        // Shifter and holding buffer take two bytes, a third is dropped
        wr(ADDR_CTRL, 16'h0063);
        wr(ADDR_DATA, 16'h00A5);
        repeat (4) @(posedge mclk);
        wr(ADDR_DATA, 16'h003C);
        wr(ADDR_DATA, 16'h0077);
        rc(ADDR_STATUS, 16'h0000);
        rc(ADDR_DATA, 16'h0000);
        getc(9'h0A5);
        getc(9'h03C);
        repeat (400) @(posedge mclk);
        chk(16'(remote.rxq.size()), 16'h0000);
        // Third char finds the queue full
        remote.send(9'h011);
        remote.send(9'h022);
        remote.send(9'h033);
        repeat (20) @(posedge mclk);
        rc(ADDR_STATUS, 16'h000F);
        rc(ADDR_DATA, 16'h0011);
        rc(ADDR_STATUS, 16'h0007);
        rc(ADDR_DATA, 16'h0022);
        rc(ADDR_STATUS, 16'h0006);
        rc(ADDR_DATA, 16'h0000);
        // Size field zero, so five data bits go each way and upper bits are dropped
        wr(ADDR_CTRL, 16'h0003);
        remote.nb = 5;
        wr(ADDR_DATA, 16'h00DA);
        getc(9'h01A);
        remote.send(9'h1F5);
        repeat (20) @(posedge mclk);
        rc(ADDR_DATA, 16'h0015);
        wr(ADDR_CTRL, 16'h00F3);
        remote.nb = 9;
        wr(ADDR_DATA, 16'h005A);
        getc(9'h15A);
        remote.send(9'h1C3);
        repeat (20) @(posedge mclk);
        rc(ADDR_STATUS, 16'h0027);
        rc(ADDR_DATA, 16'h00C3);
        wr(ADDR_CTRL, 16'h0067);
        remote.nb = 8;
        remote.bc = 8;
        wr(ADDR_DATA, 16'h00C3);
        getc(9'h0C3);
        // Sync mode ignores double speed, so a bit stays sixteen samples
        wr(ADDR_CTRL, 16'h006F);
        remote.bc = 16;
        wr(ADDR_DATA, 16'h005C);
        getc(9'h05C);
        wr(ADDR_CTRL, 16'h0063);
        wr(ADDR_BAUD, 16'h0002);
        rc(ADDR_BAUD, 16'h0002);
        remote.bc = 48;
        wr(ADDR_DATA, 16'h0096);
        getc(9'h096);
        remote.send(9'h069);
        repeat (60) @(posedge mclk);
        rc(ADDR_DATA, 16'h0069);
        wr(ADDR_BAUD, 16'h0000);
        remote.bc = 16;
        repeat (200) @(posedge mclk);
        wr(ADDR_IRQ_STAT, 16'h000F);
        rc(ADDR_IRQ_STAT, 16'h0000);
        remote.send(9'h0AA);
        repeat (20) @(posedge mclk);
        rc(ADDR_IRQ_STAT, 16'h0001);
        irq_is(1'b0);
        wr(ADDR_IRQ_MASK, 16'h0001);
        rc(ADDR_IRQ_MASK, 16'h0001);
        irq_is(1'b1);
        wr(ADDR_IRQ_STAT, 16'h0001);
        irq_is(1'b0);
        rc(ADDR_DATA, 16'h00AA);
        stop_test();
    end
endmodule // testbench
